// ---- design/rcl_pkg.sv ----
/*
 * rcl_pkg: constants for the reset-cause logic: register offsets, flag bit
 * positions, instruction decode values and reset-pulse timing.
 * Assumes a 32-bit AXI4-Lite register bus and one 200 MHz core clock.
 */
package rcl_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register map (byte addresses)
    localparam logic [3:0]  RCL_ADDR_CAUSE     = 4'h0;
    localparam logic [3:0]  RCL_ADDR_STATUS    = 4'h4;
    localparam logic [3:0]  RCL_ADDR_CONTROL   = 4'h8;

    ////////////////////////////////////////////////////////////////////////
    // reset-cause flag positions
    localparam int          RCL_BIT_POWERON    = 0;
    localparam int          RCL_BIT_BROWNOUT   = 1;
    localparam int          RCL_BIT_IDLE       = 2;
    localparam int          RCL_BIT_SLEEP      = 3;
    localparam int          RCL_BIT_WATCHDOG   = 4;
    localparam int          RCL_BIT_SOFT       = 6;
    localparam int          RCL_BIT_EXTPIN     = 7;
    localparam int          RCL_BIT_MISMATCH   = 9;
    localparam int          RCL_BIT_ILLEGAL    = 14;
    localparam int          RCL_BIT_TRAP       = 15;
    localparam logic [15:0] RCL_CAUSE_MASK     = 16'hC2DF;
    localparam logic [15:0] RCL_COLD_KEEP      = 16'h0080;

    ////////////////////////////////////////////////////////////////////////
    // decode and timing
    localparam logic [7:0]  RCL_ILLEGAL_OPHI   = 8'h3F;
    localparam logic [3:0]  RCL_HARD_TRAP_LO   = 4'hD;
    localparam logic [3:0]  RCL_HARD_TRAP_HI   = 4'hF;
    localparam logic [3:0]  RCL_WREG_KEEP      = 4'hF;
    localparam logic [23:0] RCL_RESET_VECTOR   = 24'h000000;
    localparam int          RCL_CLK_MHZ        = 200;
    localparam int          RCL_MASTER_CLEAR_PIN_MIN_NS    = 40;
    localparam int          RCL_MASTER_CLEAR_PIN_CYCLES    = (RCL_MASTER_CLEAR_PIN_MIN_NS * RCL_CLK_MHZ + 999) / 1000;
    localparam logic [7:0]  RCL_MASTER_CLEAR_PIN_CYCLES_W  = 8'(RCL_MASTER_CLEAR_PIN_CYCLES);

    typedef enum logic [2:0] {
        RCL_RUN    = 3'h1,
        RCL_HOLD   = 3'h2,
        RCL_VECTOR = 3'h4
    } rcl_state_type;

endpackage

// ---- design/rcl_pin_filter.sv ----
/*
 * rcl_pin_filter: synchronises the master-clear pin and reports a reset
 * request once it has stayed low for the minimum pulse width.
 * Assumes the pin is asynchronous to aclk.
 */
module rcl_pin_filter
    import rcl_pkg::*;
(
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // pin and result
    input  wire logic master_clear_pin_n,
    output logic      pin_reset
);

    logic       sync_a;
    logic       sync_b;
    logic [7:0] low_count;

    // sync_a feeds only sync_b
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
        end else begin
            sync_a <= master_clear_pin_n;
            sync_b <= sync_a;
        end
    end

    // short glitches never reach the count limit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            low_count <= 8'h00;
            pin_reset <= 1'b0;
        end else if (sync_b) begin
            low_count <= 8'h00;
            pin_reset <= 1'b0;
        end else if (low_count < RCL_MASTER_CLEAR_PIN_CYCLES_W) begin
            low_count <= low_count + 8'h01;
        end else begin
            pin_reset <= 1'b1;
        end
    end

endmodule

// ---- design/rcl_reset_cause.sv ----
/*
 * rcl_reset_cause: reset-source logic. Collects reset causes from the core,
 * drives the internal system reset, keeps the reset-cause register and
 * restarts the program counter at the reset vector.
 * Assumes core event inputs are one-cycle pulses on aclk, power-on and
 * brown-out arrive as synchronous pulses from the supervisor, and aresetn is
 * the power-on reset of this logic itself.
 */
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
module rcl_reset_cause
    import rcl_pkg::*;
#(
    parameter bit MISMATCH_ENABLE = 1'b1
)
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // power supervisor
    input  wire logic        power_on_event,
    input  wire logic        brownout_event,
    input  wire logic        master_clear_pin_n,
    // core events
    input  wire logic        reset_instruction,
    input  wire logic        watchdog_timeout,
    input  wire logic        power_save_sleep,
    input  wire logic        power_save_idle,
    input  wire logic        watchdog_clear_instruction,
    input  wire logic        core_in_sleep,
    input  wire logic        core_in_idle,
    input  wire logic        trap_active,
    input  wire logic [3:0]  trap_active_level,
    input  wire logic        trap_request,
    input  wire logic [3:0]  trap_request_level,
    input  wire logic [15:0] pin_select_config,
    input  wire logic [15:0] pin_select_shadow,
    input  wire logic        instr_execute,
    input  wire logic [23:0] instr_word,
    input  wire logic        pointer_use,
    input  wire logic [3:0]  pointer_reg,
    input  wire logic        wreg_write,
    input  wire logic [3:0]  wreg_write_index,
    input  wire logic        program_flow_change,
    input  wire logic        vector_flow_change,
    input  wire logic        flow_target_restricted,
    // system outputs
    output logic             system_reset_line,
    output logic             cold_reset,
    output logic             wake_request,
    output logic [15:0]      wreg_initialized,
    output logic [23:0]      program_counter_load,
    output logic             program_counter_load_valid
);

    ////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic is_hard_trap(input logic [3:0] level);
        return (level >= RCL_HARD_TRAP_LO) && (level <= RCL_HARD_TRAP_HI);
    endfunction

    logic [15:0]   reset_cause_register;
    logic [15:0]   next_cause;
    logic          hold_enable;
    rcl_state_type state;
    rcl_state_type next_state;
    logic          pin_reset;
    logic          pin_reset_d;

    rcl_pin_filter u_pin_filter (
        .aclk               (aclk),
        .aresetn            (aresetn),
        .master_clear_pin_n (master_clear_pin_n),
        .pin_reset          (pin_reset)
    );

    ////////////////////////////////////////////////////////////////////////
    // cause decode

    wire in_low_power   = core_in_sleep | core_in_idle;
    wire soft_cause     = reset_instruction;
    wire wdt_cause      = watchdog_timeout & ~in_low_power;
    wire wdt_wake       = watchdog_timeout & in_low_power;
    wire trap_cause     = trap_active & trap_request & is_hard_trap(trap_active_level)
                        & is_hard_trap(trap_request_level)
                        & (trap_request_level < trap_active_level);
    wire mismatch_cause = MISMATCH_ENABLE & (pin_select_config != pin_select_shadow);
    wire opcode_cause   = instr_execute & (instr_word[23:16] == RCL_ILLEGAL_OPHI);
    wire uninit_cause   = pointer_use & (pointer_reg != RCL_WREG_KEEP)
                        & ~wreg_initialized[pointer_reg];
    wire security_cause = (program_flow_change | vector_flow_change)
                        & flow_target_restricted;
    wire illegal_cause  = opcode_cause | uninit_cause | security_cause;
    wire pin_rise       = pin_reset & ~pin_reset_d;
    wire cold_cause     = power_on_event | brownout_event;
    wire warm_cause     = soft_cause | wdt_cause | trap_cause | mismatch_cause
                        | illegal_cause | pin_rise;

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite slave

    logic        aw_held;
    logic        w_held;
    logic [3:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;

    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    wire        aw_now     = aw_held | (s_axi_awvalid & s_axi_awready);
    wire        w_now      = w_held | (s_axi_wvalid & s_axi_wready);
    wire [3:0]  wr_addr    = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] wr_data    = w_held ? w_data : s_axi_wdata;
    wire [3:0]  wr_strb    = w_held ? w_strb : s_axi_wstrb;
    wire        wr_fire    = aw_now & w_now & ~s_axi_bvalid;
    wire        wr_cause   = wr_fire & (wr_addr == RCL_ADDR_CAUSE);
    wire        wr_control = wr_fire & (wr_addr == RCL_ADDR_CONTROL);
    wire        wr_ok      = (wr_addr == RCL_ADDR_CAUSE) | (wr_addr == RCL_ADDR_CONTROL);
    wire [15:0] wr_mask    = {{8{wr_strb[1]}}, {8{wr_strb[0]}}} & RCL_CAUSE_MASK;
    wire        rd_ok      = (s_axi_araddr == RCL_ADDR_CAUSE) | (s_axi_araddr == RCL_ADDR_STATUS)
                           | (s_axi_araddr == RCL_ADDR_CONTROL);
    wire [31:0] rd_value   = (s_axi_araddr == RCL_ADDR_CAUSE)   ? {16'h0000, reset_cause_register} :
                             (s_axi_araddr == RCL_ADDR_STATUS)  ? {29'h00000000, cold_reset,
                                                                   state == RCL_HOLD, system_reset_line} :
                             (s_axi_araddr == RCL_ADDR_CONTROL) ? {31'h00000000, hold_enable} :
                                                                  32'h00000000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 4'h0;
            w_data  <= 32'h00000000;
            w_strb  <= 4'h0;
        end else begin
            aw_held <= aw_now & ~wr_fire;
            w_held  <= w_now & ~wr_fire;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= 2'h0;
            s_axi_rdata  <= 32'h00000000;
        end else begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid & s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
                s_axi_rdata  <= rd_value;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset-cause register

    always_comb begin
        next_cause = reset_cause_register;
        // software first, so a same-cycle hardware event still wins
        if (wr_cause) begin
            next_cause = (next_cause & ~wr_mask) | (wr_data[15:0] & wr_mask);
        end
        if (power_save_sleep | power_save_idle | watchdog_clear_instruction | cold_cause) begin
            next_cause[RCL_BIT_WATCHDOG] = 1'b0;
        end
        if (cold_cause) begin
            next_cause = next_cause & RCL_COLD_KEEP;
        end
        if (power_on_event) begin
            next_cause[RCL_BIT_EXTPIN]  = 1'b0;
            next_cause[RCL_BIT_POWERON] = 1'b1;
        end
        if (cold_cause) begin
            next_cause[RCL_BIT_BROWNOUT] = 1'b1;
        end
        // several causes may set together; warm resets keep the rest
        if (soft_cause)     next_cause[RCL_BIT_SOFT]     = 1'b1;
        // a time-out in sleep or idle only wakes, but it still leaves its flag
        if (watchdog_timeout) next_cause[RCL_BIT_WATCHDOG] = 1'b1;
        if (trap_cause)     next_cause[RCL_BIT_TRAP]     = 1'b1;
        if (mismatch_cause) next_cause[RCL_BIT_MISMATCH] = 1'b1;
        if (illegal_cause)  next_cause[RCL_BIT_ILLEGAL]  = 1'b1;
        if (pin_rise)       next_cause[RCL_BIT_EXTPIN]   = 1'b1;
        if (power_save_sleep) next_cause[RCL_BIT_SLEEP]  = 1'b1;
        if (power_save_idle)  next_cause[RCL_BIT_IDLE]   = 1'b1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reset_cause_register <= 16'h0003;
            hold_enable          <= 1'b0;
            pin_reset_d          <= 1'b0;
        end else begin
            reset_cause_register <= next_cause;
            pin_reset_d          <= pin_reset;
            if (wr_control & wr_strb[0]) begin
                hold_enable <= wr_data[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // system reset sequencing

    // the watchdog path is combinational so it reaches the core at once
    assign system_reset_line = (state != RCL_RUN) | wdt_cause | cold_cause | pin_reset;
    assign wake_request      = wdt_wake;

    always_comb begin
        case (state)
            RCL_RUN:    next_state = (warm_cause | cold_cause) ? RCL_HOLD : RCL_RUN;
            // release one cycle later; a held pin or hold_enable stretches it
            RCL_HOLD:   next_state = (pin_reset | cold_cause | hold_enable) ? RCL_HOLD : RCL_VECTOR;
            RCL_VECTOR: next_state = RCL_RUN;
            default:    next_state = RCL_HOLD;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state      <= RCL_HOLD;
            cold_reset <= 1'b1;
        end else begin
            state <= next_state;
            if (cold_cause) begin
                cold_reset <= 1'b1;
            end else if (warm_cause) begin
                cold_reset <= 1'b0;
            end
        end
    end

    // pointer-use tracking: reset clears all but the stack register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wreg_initialized           <= 16'h8000;
            program_counter_load       <= RCL_RESET_VECTOR;
            program_counter_load_valid <= 1'b0;
        end else begin
            if (state == RCL_HOLD) begin
                wreg_initialized <= 16'h8000;
            end else if (wreg_write) begin
                wreg_initialized[wreg_write_index] <= 1'b1;
            end
            program_counter_load       <= RCL_RESET_VECTOR;
            program_counter_load_valid <= (state == RCL_VECTOR);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    sequence soft_hit;
        state == RCL_RUN && reset_instruction && !cold_cause && !pin_reset;
    endsequence
    sequence release_then_fetch;
        (state == RCL_HOLD && system_reset_line) ##1 (state == RCL_VECTOR) ##1 program_counter_load_valid;
    endsequence

    a_soft_release: assert property (@(posedge aclk) disable iff (!aresetn)
        soft_hit ##0 !hold_enable ##1 !hold_enable |-> release_then_fetch)
        else $error("soft reset not released in one cycle");
    a_soft_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        reset_instruction && !cold_cause |=> reset_cause_register[RCL_BIT_SOFT])
        else $error("soft flag not set");
    a_wdt_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        wdt_cause |-> system_reset_line)
        else $error("watchdog did not reset");
    a_wdt_wake: assert property (@(posedge aclk) disable iff (!aresetn)
        watchdog_timeout && in_low_power && state == RCL_RUN && !warm_cause && !cold_cause
        |-> wake_request && !system_reset_line ##1 state == RCL_RUN)
        else $error("watchdog in low power reset device");
    a_wdt_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        watchdog_clear_instruction && !watchdog_timeout |=> !reset_cause_register[RCL_BIT_WATCHDOG])
        else $error("watchdog flag not cleared");
    a_trap_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        trap_cause && !cold_cause |=> reset_cause_register[RCL_BIT_TRAP] && system_reset_line)
        else $error("trap conflict missed");
    a_illegal_flag: assert property (@(posedge aclk) disable iff (!aresetn)
        instr_execute && instr_word[23:16] == RCL_ILLEGAL_OPHI && !cold_cause
        |=> reset_cause_register[RCL_BIT_ILLEGAL])
        else $error("illegal opcode flag not set");
    a_cold_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        brownout_event && !power_on_event && !warm_cause && !wr_cause && !power_save_sleep && !power_save_idle
        |=> reset_cause_register == (($past(reset_cause_register) & RCL_COLD_KEEP) | 16'h0002))
        else $error("brown-out flag update wrong");
    a_soft_write: assert property (@(posedge aclk) disable iff (!aresetn)
        state == RCL_RUN && wr_cause && !warm_cause && !cold_cause && !pin_reset && !hold_enable
        |=> state == RCL_RUN)
        else $error("register write caused reset");

endmodule

// ---- verification/rcl_reset_cause_test.sv ----
/*
 * rcl_reset_cause_test: self-checking bench for the reset-cause logic, driving
 * its AXI4-Lite port and core event inputs straight from tasks.
 * Assumes the design package rcl_pkg and a single 200 MHz aclk.
 */
module rcl_reset_cause_test
    import rcl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        power_on_event = 1'b0, brownout_event = 1'b0, master_clear_pin_n = 1'b1;
    logic        reset_instruction = 1'b0, watchdog_timeout = 1'b0, power_save_sleep = 1'b0;
    logic        power_save_idle = 1'b0, watchdog_clear_instruction = 1'b0, core_in_sleep = 1'b0;
    logic        core_in_idle = 1'b0, trap_active = 1'b0, trap_request = 1'b0, instr_execute = 1'b0;
    logic        pointer_use = 1'b0, wreg_write = 1'b0, program_flow_change = 1'b0;
    logic        vector_flow_change = 1'b0, flow_target_restricted = 1'b0;
    logic [3:0]  trap_active_level = 4'h0, trap_request_level = 4'h0, pointer_reg = 4'h0;
    logic [3:0]  wreg_write_index = 4'h0;
    logic [15:0] pin_select_config = 16'h0000, pin_select_shadow = 16'h0000, wreg_initialized;
    logic [23:0] instr_word = 24'h000000, program_counter_load;
    logic        system_reset_line, cold_reset, wake_request, program_counter_load_valid;
    int          errors, checks_done, pc_count;

    // one entry per event: preset flags, expected flags, whether a reset follows
    localparam logic [15:0] PRE [20] = '{16'h0201, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0010, 16'h0010, 16'h0000,
        16'h0010, 16'hC2DF, 16'h0080, 16'h0000, 16'h0000};
    localparam logic [15:0] EXP [20] = '{16'h0241, 16'h0010, 16'h8000, 16'h0200, 16'h4000, 16'h4000,
        16'h4000, 16'h4000, 16'h0010, 16'h0000, 16'h0000, 16'h0000, 16'h0008, 16'h0004, 16'h0000,
        16'h0000, 16'h0082, 16'h0003, 16'h0010, 16'h0080};
    localparam logic [19:0] RST = 20'hB00FF;

    rcl_reset_cause rcl_reset_cause_inst (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .power_on_event, .brownout_event, .master_clear_pin_n, .reset_instruction, .watchdog_timeout,
        .power_save_sleep, .power_save_idle, .watchdog_clear_instruction, .core_in_sleep, .core_in_idle,
        .trap_active, .trap_active_level, .trap_request, .trap_request_level, .pin_select_config,
        .pin_select_shadow, .instr_execute, .instr_word, .pointer_use, .pointer_reg, .wreg_write,
        .wreg_write_index, .program_flow_change, .vector_flow_change, .flow_target_restricted,
        .system_reset_line, .cold_reset, .wake_request, .wreg_initialized, .program_counter_load,
        .program_counter_load_valid);

    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2.5 aclk = ~aclk;
    end

    task automatic stop_test();
        if (errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // handshakes are judged at the falling edge, since inputs only move at rising edges
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] resp);
        bit ah, wh, bh;
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100 && !bh; n++) begin
            @(negedge aclk);
            ah = s_axi_awvalid && s_axi_awready;
            wh = s_axi_wvalid && s_axi_wready;
            bh = s_axi_bready && s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge aclk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            if (bh) s_axi_bready <= 1'b0;
        end
        chk(bh, 1'b1);
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] resp);
        bit ah, rh;
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100 && !rh; n++) begin
            @(negedge aclk);
            ah = s_axi_arvalid && s_axi_arready;
            rh = s_axi_rready && s_axi_rvalid;
            d = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (ah) s_axi_arvalid <= 1'b0;
            if (rh) s_axi_rready <= 1'b0;
        end
        chk(rh, 1'b1);
    endtask

    // raises (v=1) or drops (v=0) the stimulus of event k
    task automatic drive(input int k, input bit v);
        reset_instruction <= v & (k == 0);
        watchdog_timeout <= v & (k == 1 || k == 8 || k == 18);
        trap_active <= v & (k == 2 || k == 11);
        trap_request <= v & (k == 2 || k == 11);
        trap_active_level <= (k == 2) ? 4'hF : 4'hD;
        trap_request_level <= (k == 2) ? 4'hD : 4'hE;
        pin_select_config <= 16'(v & (k == 3));
        instr_execute <= v & (k == 4 || k == 9);
        instr_word <= (k == 4) ? 24'h3F0000 : 24'h3E0000;
        pointer_use <= v & (k == 5 || k == 10);
        pointer_reg <= (k == 5) ? 4'h3 : 4'hF;
        program_flow_change <= v & (k == 6 || k == 14);
        vector_flow_change <= v & (k == 7);
        flow_target_restricted <= v & (k == 6 || k == 7);
        core_in_sleep <= v & (k == 8);
        core_in_idle <= v & (k == 18);
        power_save_sleep <= v & (k == 12);
        power_save_idle <= v & (k == 13);
        watchdog_clear_instruction <= v & (k == 15);
        brownout_event <= v & (k == 16);
        power_on_event <= v & (k == 17);
        master_clear_pin_n <= !(v & (k == 19));
    endtask

    task automatic wait_quiet();
        int n;
        for (n = 0; n < 200 && system_reset_line !== 1'b0; n++)
            @(negedge aclk);
        chk(n < 200, 1'b1);
    endtask

    always @(negedge aclk) begin
        if (program_counter_load_valid === 1'b1) begin
            pc_count++;
            chk(program_counter_load, 32'h0);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        int          hi, pc0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        wait_quiet();
        axi_rd(RCL_ADDR_CAUSE, d, r);
        chk(d, 32'h0003);
        chk(pc_count != 0, 1'b1);
        axi_wr(RCL_ADDR_CAUSE, 32'hFFFFFFFF, r);
        axi_rd(RCL_ADDR_CAUSE, d, r);
        chk(d, 32'hC2DF);
        axi_wr(4'hC, 32'h0, r);
        chk(r, 2'b10);
        axi_rd(4'hC, d, r);
        chk({r, d[29:0]}, 32'h80000000);
        for (int k = 0; k < 20; k++) begin
            axi_wr(RCL_ADDR_CAUSE, {16'h0000, PRE[k]}, r);
            @(negedge aclk);
            chk(system_reset_line, 1'b0);
            pc0 = pc_count;
            @(posedge aclk);
            drive(k, 1'b1);
            @(negedge aclk);
            if (k == 8 || k == 18) chk({system_reset_line, wake_request}, 2'b01);
            if (k == 1) chk(system_reset_line, 1'b1);
            repeat (k == 19 ? 12 : 1) @(posedge aclk);
            drive(k, 1'b0);
            hi = 0;
            repeat (40) begin
                @(negedge aclk);
                hi += (system_reset_line === 1'b1);
            end
            chk(hi != 0, RST[k]);
            if (k == 0) chk(hi <= 3, 1'b1);
            wait_quiet();
            chk(pc_count != pc0, RST[k]);
            if (RST[k]) chk(cold_reset, k == 16 || k == 17);
            axi_rd(RCL_ADDR_CAUSE, d, r);
            chk(d, {16'h0000, EXP[k]});
        end
        stop_test();
    end

    // whole run is about a thousand cycles; this is ample headroom
    initial begin
        #100us;
        errors++;
        stop_test();
    end

endmodule
